// >>> vtc_core.sv
// Vicinity tag command interpreter: downlink decode, request handling,
// block memory with locks, uplink bit stream and APB register port.
// Assumes an analog front end that reports slot ticks and pauses, and
// that turns the uplink bit stream into subcarrier modulation.

// Functional notes
// - Reply only after a received request frame; never transmit unprompted.
// - Accept both addressed requests (UID) and non-addressed requests.
// - Decode pulse position coding, one-of-four and one-of-256.
// - Uplink supports single and dual subcarrier at high and low rate.
// - Reply uses the subcarrier and rate flags of the request.
// - Frames are delimited and CRC protected; received CRC is checked.
// - Hold 64-bit factory UID and match it in addressed requests.
// - Join anticollision inventory by AFI and UID mask match.
// - Store, report, write and lock AFI and DSFID.
// - User memory is 64 blocks of 32 bits, each writable and lockable.
// - A set lock bit never clears; locked data never changes.
// - User and factory lock per block; factory lock at security bit 2.
// - System info reports IC reference, block size and block count.
// - Inventory flag also works with read, system info, security reads.
// - 0x01 is inventory, 0x02 stay quiet, quiet only when addressed.
// - Decode optional codes 0x20 to 0x2C as listed.
// - 0xA2 writes two blocks, 0xA3 locks two blocks.
// - Write and lock commands need option flag bit 7 set.
module vtc_core import vtc_pkg::*; #(
  parameter logic [63:0] UID    = 64'hE012_3456_789A_BCDE, // arbitrary value
  parameter logic [7:0]  IC_REF = 8'h5A                    // arbitrary value
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Downlink from front end
  input  wire logic        dl_sof,
  input  wire logic        dl_sof_256,
  input  wire logic        dl_slot,
  input  wire logic        dl_pulse,
  input  wire logic        dl_eof,
  // Uplink to front end
  output logic             ul_frame,
  output logic             ul_valid,
  output logic             ul_bit,
  input  wire logic        ul_ready,
  output logic             ul_dual_sc,
  output logic             ul_fast
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    vtc_seq_t                       seq;
    vtc_tag_t                       tag;
    logic                           en;
    logic                           rx_act;
    logic                           c256;
    logic                           seen;
    logic                           bad;
    logic [7:0]                     slot;
    logic [7:0]                     pos;
    logic [7:0]                     rx_sh;
    logic [1:0]                     nsym;
    logic [RX_MAX-1:0][7:0]         rx;
    logic [5:0]                     rxlen;
    logic [HDR_MAX-1:0][7:0]        hdr;
    logic [4:0]                     hlen;
    logic [4:0]                     hi;
    vtc_ph_t                        ph;
    logic [7:0]                     sh;
    logic [3:0]                     bcnt;
    logic [5:0]                     sblk;
    logic [6:0]                     sleft;
    logic [2:0]                     sub;
    logic                           ssec;
    logic                           sonly;
    logic [NBLK-1:0][BLK_W-1:0]     mem;
    logic [NBLK-1:0]                ulock;
    logic [NBLK-1:0]                flock;
    logic [7:0]                     afi;
    logic [7:0]                     dsfid;
    logic                           afi_lk;
    logic                           dsfid_lk;
    logic                           dual;
    logic                           fast;
    logic [8:0]                     fblk;
    logic [7:0]                     lastcmd;
    logic [7:0]                     nframes;
    logic [31:0]                    prdata;
    logic                           pslverr;
  } vtc_core_t;

  vtc_core_t q, d;

  logic        rx_ld, tx_init, tx_ld, take;
  logic [7:0]  rx_byte, tx_byte, fl, cmd, sym, b0, err;
  logic [5:0]  p, mbytes;
  logic [6:0]  mlen;
  logic [63:0] mask_v, mmask, uid_rx;
  logic [8:0]  span;
  logic [15:0] rx_crc, tx_crc;

  function automatic logic [7:0] sec_of(input logic u, input logic f);
    sec_of = 8'h00;
    sec_of[SEC_USER] = u;
    sec_of[SEC_FACT] = f;
  endfunction

  function automatic logic [7:0] rxb(input vtc_core_t s, input logic [5:0] i);
    rxb = (i < 6'(RX_MAX)) ? s.rx[i[4:0]] : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // CRC engines
  // ----------------------------------------------------------------
  vtc_crc16 u_rx_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (dl_sof),
    .load    (rx_ld),
    .din     (rx_byte),
    .crc     (rx_crc)
  );

  vtc_crc16 u_tx_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (tx_init),
    .load    (tx_ld),
    .din     (tx_byte),
    .crc     (tx_crc)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    rx_ld = 1'b0;
    rx_byte = 8'h00;
    tx_init = 1'b0;
    tx_ld = 1'b0;
    tx_byte = 8'h00;
    take = 1'b0;
    fl = q.rx[0];
    cmd = q.rx[1];
    sym = 8'h00;
    b0 = 8'h00;
    err = 8'h00;
    p = 6'd2;
    mbytes = 6'd0;
    mlen = 7'd0;
    mask_v = '0;
    mmask = '0;
    uid_rx = '0;
    span = 9'd0;

    // Pulse position decoder, LSB pair first in one-of-four
    if (q.seq == SQ_RX) begin
      if (dl_sof) begin
        d.rx_act = 1'b1;
        d.c256 = dl_sof_256;
        d.slot = 8'h00;
        d.nsym = 2'd0;
        d.rxlen = 6'd0;
        d.seen = 1'b0;
        d.bad = 1'b0;
      end else if (q.rx_act) begin
        if (dl_pulse) begin
          d.pos = q.slot;
          d.seen = 1'b1;
        end
        if (dl_slot) begin
          if (q.slot == (q.c256 ? SLOT_LAST256 : SLOT_LAST4)) begin
            d.slot = 8'h00;
            d.seen = 1'b0;
            sym = dl_pulse ? q.slot : q.pos;
            if (!dl_pulse && !q.seen) begin
              d.bad = 1'b1; // Symbol without a pause is a broken frame
            end
            if (q.c256) begin
              rx_ld = 1'b1;
              rx_byte = sym;
            end else begin
              rx_byte = {sym[1:0], q.rx_sh[7:2]};
              d.rx_sh = rx_byte;
              d.nsym = q.nsym + 2'd1;
              rx_ld = (q.nsym == 2'd3);
            end
            if (rx_ld) begin
              if (q.rxlen < 6'(RX_MAX)) begin
                d.rx[q.rxlen[4:0]] = rx_byte;
                d.rxlen = q.rxlen + 6'd1;
              end else begin
                d.bad = 1'b1; // Too long for any supported request
              end
            end
          end else begin
            d.slot = q.slot + 8'h01;
          end
        end
        if (dl_eof) begin
          d.rx_act = 1'b0;
          d.seq = SQ_EXEC;
        end
      end
    end

    // Request handling, one cycle after the end of frame
    if (q.seq == SQ_EXEC) begin
      d.seq = SQ_RX;
      if (q.en && !q.bad && q.rxlen >= 6'd4 && rx_crc == CRC_GOOD) begin
        d.nframes = q.nframes + 8'h01;
        d.lastcmd = cmd;
        if (fl[F_INV]) begin
          // Inventory addressing: AFI, then mask over UID LSBs
          p = fl[F_AFI] ? 6'd3 : 6'd2;
          mlen = (rxb(q, p) > 8'd64) ? 7'd64 : 7'(rxb(q, p));
          mbytes = 6'((mlen + 7'd7) >> 3);
          for (int i = 0; i < 8; i++) begin
            mask_v[8*i +: 8] = rxb(q, p + 6'd1 + 6'(i));
          end
          mmask = (mlen == 7'd64) ? '1 : ((64'h1 << mlen) - 64'h1);
          p = p + 6'd1 + mbytes;
          take = (q.tag != ST_QUIET) && ((fl[F_AFI] ? rxb(q, 6'd3) : rxb(q, 6'd2)) <= 8'd64)
               && (!fl[F_AFI] || rxb(q, 6'd2) == 8'h00 || rxb(q, 6'd2) == q.afi)
               && (((mask_v ^ UID) & mmask) == '0)
               && (cmd == C_INV || cmd == C_RD1 || cmd == C_RDM
                   || cmd == C_SYS || cmd == C_MSEC);
        end else begin
          for (int i = 0; i < 8; i++) begin
            uid_rx[8*i +: 8] = rxb(q, 6'd2 + 6'(i));
          end
          if (fl[F_ADDR]) begin
            p = 6'd10;
            take = (uid_rx == UID) && !fl[F_SEL];
          end else if (fl[F_SEL]) begin
            take = (q.tag == ST_SELECTED);
          end else begin
            take = (q.tag != ST_QUIET);
          end
          if ((cmd == C_QUIET || cmd == C_SEL) && !fl[F_ADDR]) begin
            take = 1'b0;
          end
          if (cmd == C_INV) begin
            take = 1'b0;
          end
        end
        take = take && (q.rxlen >= p + vtc_need(cmd) + 6'd2);
        b0 = rxb(q, p);
        span = (cmd == C_RDM || cmd == C_MSEC) ? {1'b0, rxb(q, p + 6'd1)} + 9'd1 : 9'd1;
        if (cmd == C_WR2 || cmd == C_LK2) begin
          span = 9'd2;
        end
        d.hlen = 5'd1;
        d.hdr[0] = RSP_OK;
        d.sleft = 7'd0;
        if (take) begin
          d.seq = SQ_TX;
          // Write and lock commands demand the option flag
          if ((cmd == C_WR1 || cmd == C_LK1 || cmd == C_WR2 || cmd == C_LK2
               || (cmd >= C_WAFI && cmd <= C_LDSF)) && !fl[F_OPT]) begin
            err = ERR_OPT;
          end else if ((cmd == C_RD1 || cmd == C_WR1 || cmd == C_LK1 || cmd == C_RDM
                       || cmd == C_MSEC || cmd == C_WR2 || cmd == C_LK2)
                       && ({1'b0, b0} + span > 9'(NBLK))) begin
            err = ERR_RANGE;
          end
          if (err == 8'h00) begin
            case (cmd)
              C_INV: begin
                d.hdr[1] = q.dsfid;
                for (int i = 0; i < 8; i++) begin
                  d.hdr[2+i] = UID[8*i +: 8];
                end
                d.hlen = 5'd10;
              end
              C_QUIET: begin
                d.tag = ST_QUIET;
                d.seq = SQ_RX; // No reply to stay quiet
              end
              C_RD1, C_RDM, C_MSEC: begin
                d.sblk = b0[5:0];
                d.sleft = span[6:0];
                d.sonly = (cmd == C_MSEC);
                d.ssec = fl[F_OPT] || (cmd == C_MSEC);
                d.sub = (fl[F_OPT] || cmd == C_MSEC) ? 3'd0 : 3'd1;
              end
              C_WR1, C_WR2: begin
                for (int k = 0; k < 2; k++) begin
                  if (k < int'(span) && (q.ulock[b0[5:0] + 6'(k)]
                                         || q.flock[b0[5:0] + 6'(k)])) begin
                    err = ERR_NOCHG;
                  end
                end
                if (err == 8'h00) begin
                  for (int k = 0; k < 2; k++) begin
                    if (k < int'(span)) begin
                      for (int j = 0; j < 4; j++) begin
                        d.mem[b0[5:0] + 6'(k)][8*j +: 8] = rxb(q, p + 6'(1 + 4*k + j));
                      end
                    end
                  end
                end
              end
              C_LK1, C_LK2: begin
                for (int k = 0; k < 2; k++) begin
                  if (k < int'(span)) begin
                    if (q.ulock[b0[5:0] + 6'(k)]) begin
                      err = ERR_LOCKED;
                    end
                    d.ulock[b0[5:0] + 6'(k)] = 1'b1;
                  end
                end
              end
              C_SEL: begin
                d.tag = ST_SELECTED;
              end
              C_RTR: begin
                d.tag = ST_READY;
              end
              C_WAFI, C_LAFI: begin
                if (q.afi_lk) begin
                  err = ERR_NOCHG;
                end else if (cmd == C_WAFI) begin
                  d.afi = b0;
                end else begin
                  d.afi_lk = 1'b1;
                end
              end
              C_WDSF, C_LDSF: begin
                if (q.dsfid_lk) begin
                  err = ERR_NOCHG;
                end else if (cmd == C_WDSF) begin
                  d.dsfid = b0;
                end else begin
                  d.dsfid_lk = 1'b1;
                end
              end
              C_SYS: begin
                d.hdr[1] = INFO_FLAGS;
                for (int i = 0; i < 8; i++) begin
                  d.hdr[2+i] = UID[8*i +: 8];
                end
                d.hdr[10] = q.dsfid;
                d.hdr[11] = q.afi;
                d.hdr[12] = 8'(NBLK - 1);
                d.hdr[13] = 8'(BLK_W / 8 - 1);
                d.hdr[14] = IC_REF;
                d.hlen = 5'd15;
              end
              default: begin
                d.seq = SQ_RX;
                d.nframes = q.nframes;
              end
            endcase
          end
          if (err != 8'h00) begin
            d.hdr[0] = RSP_ERR;
            d.hdr[1] = err;
            d.hlen = 5'd2;
            d.sleft = 7'd0;
          end
          if (d.seq == SQ_TX) begin
            tx_init = 1'b1;
            d.ph = PH_HDR;
            d.hi = 5'd0;
            d.bcnt = 4'd0;
            d.dual = fl[F_SUBC];
            d.fast = fl[F_RATE];
          end
        end
      end
    end

    // Uplink bytes LSB first, CRC complement appended low byte first
    if (q.seq == SQ_TX) begin
      if (q.bcnt == 4'd0) begin
        case (q.ph)
          PH_HDR: begin
            tx_byte = q.hdr[q.hi[3:0]];
            tx_ld = 1'b1;
            d.hi = q.hi + 5'd1;
            if (q.hi == q.hlen - 5'd1) begin
              d.ph = (q.sleft != 7'd0) ? PH_STR : PH_CRC0;
            end
          end
          PH_STR: begin
            tx_byte = (q.sub == 3'd0) ? sec_of(q.ulock[q.sblk], q.flock[q.sblk])
                    : q.mem[q.sblk][8*(q.sub - 3'd1) +: 8];
            tx_ld = 1'b1;
            if (q.sub == (q.sonly ? 3'd0 : 3'd4)) begin
              d.sub = q.ssec ? 3'd0 : 3'd1;
              d.sblk = q.sblk + 6'd1;
              d.sleft = q.sleft - 7'd1;
              if (q.sleft == 7'd1) begin
                d.ph = PH_CRC0;
              end
            end else begin
              d.sub = q.sub + 3'd1;
            end
          end
          PH_CRC0: begin
            tx_byte = ~tx_crc[7:0];
            d.ph = PH_CRC1;
          end
          PH_CRC1: begin
            tx_byte = ~tx_crc[15:8];
            d.ph = PH_DONE;
          end
          default: begin
            d.seq = SQ_RX;
          end
        endcase
        if (q.ph != PH_DONE) begin
          d.sh = tx_byte;
          d.bcnt = 4'd8;
        end
      end else if (ul_ready) begin
        d.sh = q.sh >> 1;
        d.bcnt = q.bcnt - 4'd1;
      end
    end

    // APB read data captured in the setup phase
    if (psel && !penable) begin
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      if (paddr == A_CTRL) begin
        d.prdata = {31'h0000_0000, q.en};
      end else if (paddr == A_STATUS) begin
        d.prdata = {q.nframes, q.lastcmd, 12'h000, q.tag, q.seq};
      end else if (paddr == A_FBLK) begin
        d.prdata = {23'h00_0000, q.fblk};
      end else if (paddr == A_FDATA) begin
        d.prdata = q.mem[q.fblk[5:0]];
      end else if (paddr == A_IDS) begin
        d.prdata = {14'h0000, q.afi_lk, q.dsfid_lk, q.afi, q.dsfid};
      end else begin
        d.pslverr = 1'b1;
      end
    end

    // APB writes; factory path respects locks as the air path does
    if (psel && penable && pwrite) begin
      if (paddr == A_CTRL) begin
        d.en = pwdata[0];
      end else if (paddr == A_FBLK) begin
        d.fblk = pwdata[8:0];
      end else if (paddr == A_FDATA) begin
        if (!q.ulock[q.fblk[5:0]] && !q.flock[q.fblk[5:0]]) begin
          d.mem[q.fblk[5:0]] = pwdata;
          d.flock[q.fblk[5:0]] = q.fblk[8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers; all enums reset to their first value
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign pready     = psel & penable;
  assign prdata     = q.prdata;
  assign pslverr    = q.pslverr;
  assign ul_frame   = (q.seq == SQ_TX);
  assign ul_valid   = (q.seq == SQ_TX) && (q.bcnt != 4'd0);
  assign ul_bit     = q.sh[0];
  assign ul_dual_sc = q.dual;
  assign ul_fast    = q.fast;
endmodule // vtc_core

// >>> vtc_pkg.sv
// Shared constants and types for the vicinity tag command logic.
// Assumes one clock domain (pclk) and an APB register port.
package vtc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NBLK    = 64;
  localparam int BLK_W   = 32;
  localparam int RX_MAX  = 24;
  localparam int HDR_MAX = 16;

  // ----------------------------------------------------------------
  // Request flag positions and command codes
  // ----------------------------------------------------------------
  localparam int F_SUBC = 0;
  localparam int F_RATE = 1;
  localparam int F_INV  = 2;
  localparam int F_SEL  = 4;
  localparam int F_ADDR = 5;
  localparam int F_AFI  = 4;
  localparam int F_OPT  = 7;

  localparam logic [7:0] C_INV  = 8'h01;
  localparam logic [7:0] C_QUIET = 8'h02;
  localparam logic [7:0] C_RD1  = 8'h20;
  localparam logic [7:0] C_WR1  = 8'h21;
  localparam logic [7:0] C_LK1  = 8'h22;
  localparam logic [7:0] C_RDM  = 8'h23;
  localparam logic [7:0] C_SEL  = 8'h25;
  localparam logic [7:0] C_RTR  = 8'h26;
  localparam logic [7:0] C_WAFI = 8'h27;
  localparam logic [7:0] C_LAFI = 8'h28;
  localparam logic [7:0] C_WDSF = 8'h29;
  localparam logic [7:0] C_LDSF = 8'h2A;
  localparam logic [7:0] C_SYS  = 8'h2B;
  localparam logic [7:0] C_MSEC = 8'h2C;
  localparam logic [7:0] C_WR2  = 8'hA2;
  localparam logic [7:0] C_LK2  = 8'hA3;

  // ----------------------------------------------------------------
  // Reply codes, security bits, CRC
  // ----------------------------------------------------------------
  localparam logic [7:0] RSP_OK     = 8'h00;
  localparam logic [7:0] RSP_ERR    = 8'h01;
  localparam logic [7:0] ERR_OPT    = 8'h0F;
  localparam logic [7:0] ERR_RANGE  = 8'h10;
  localparam logic [7:0] ERR_LOCKED = 8'h11;
  localparam logic [7:0] ERR_NOCHG  = 8'h12;
  localparam logic [7:0] INFO_FLAGS = 8'h0F;
  localparam int SEC_USER = 0;
  localparam int SEC_FACT = 2;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [7:0]  SLOT_LAST4   = 8'h03;
  localparam logic [7:0]  SLOT_LAST256 = 8'hFF;

  // ----------------------------------------------------------------
  // APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_FBLK   = 8'h08;
  localparam logic [7:0] A_FDATA  = 8'h0C;
  localparam logic [7:0] A_IDS    = 8'h10;

  typedef enum logic [1:0] {ST_READY, ST_QUIET, ST_SELECTED} vtc_tag_t;
  typedef enum logic [1:0] {SQ_RX, SQ_EXEC, SQ_TX} vtc_seq_t;
  typedef enum logic [2:0] {PH_HDR, PH_STR, PH_CRC0, PH_CRC1, PH_DONE} vtc_ph_t;

  // Parameter bytes a command needs after its flags/address part
  function automatic logic [5:0] vtc_need(input logic [7:0] c);
    case (c)
      C_RD1, C_LK1, C_WAFI, C_WDSF, C_LK2: vtc_need = 6'd1;
      C_RDM, C_MSEC:                       vtc_need = 6'd2;
      C_WR1:                               vtc_need = 6'd5;
      C_WR2:                               vtc_need = 6'd9;
      default:                             vtc_need = 6'd0;
    endcase
  endfunction

endpackage

// >>> vtc_crc16.sv
// Byte-wide CRC-16 (reflected) register used for both link directions.
// Assumes init and load are never high together.
module vtc_crc16 import vtc_pkg::*; (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        init,
  input  wire logic        load,
  input  wire logic [7:0]  din,
  // Result
  output logic      [15:0] crc
);
  typedef struct packed { logic [15:0] c; } vtc_crc_t;
  vtc_crc_t q, d;

  // One byte, LSB first, per load
  always_comb begin
    d = q;
    if (init) begin
      d.c = CRC_INIT;
    end else if (load) begin
      for (int i = 0; i < 8; i++) begin
        d.c = (d.c[0] ^ din[i]) ? ((d.c >> 1) ^ CRC_POLY) : (d.c >> 1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{c: CRC_INIT};
    end else begin
      q <= d;
    end
  end

  assign crc = q.c;
endmodule // vtc_crc16

// >>> vtc_core_chk.sv
// Checker for vtc_core: reply framing and APB answers.
// Assumes one clock, pclk, and the active-low reset presetn.
module vtc_core_chk (
  // Clock, reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Link
  input wire logic        dl_eof,
  input wire logic        ul_frame,
  input wire logic        ul_valid,
  input wire logic        ul_bit,
  input wire logic        ul_ready,
  input wire logic        ul_dual_sc,
  input wire logic        ul_fast
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  // Reply opens with one idle cycle, then the first bit
  sequence s_lead;
    !ul_valid ##1 ul_valid;
  endsequence
  a_no_unprompted: assert property ($rose(ul_frame) |-> $past(dl_eof, 2))
    else $error("reply without request");
  a_valid_framed: assert property (ul_valid |-> ul_frame)
    else $error("bit outside frame");
  a_reply_lead: assert property ($rose(ul_frame) |-> s_lead)
    else $error("bad reply start");
  a_bit_holds: assert property (ul_valid && !ul_ready |=> ul_valid && $stable(ul_bit))
    else $error("bit lost");
  a_mode_holds: assert property (ul_frame && $past(ul_frame) |-> $stable({ul_dual_sc, ul_fast}))
    else $error("mode moved");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("wait state");
  a_apb_unmapped: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("no slave error");
  a_err_rdata: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("data on error");
endmodule // vtc_core_chk

bind vtc_core vtc_core_chk i_chk (.*);

// >>> vtc_reader_model.sv
// Reader model: sends coded request frames, collects reply bytes.
// Assumes one-cycle slot ticks from the front end.
module vtc_reader_model import vtc_pkg::*; (
  // Clock
  input  wire logic pclk,
  // Downlink
  output logic      dl_sof,
  output logic      dl_sof_256,
  output logic      dl_slot,
  output logic      dl_pulse,
  output logic      dl_eof,
  // Uplink
  input  wire logic ul_frame,
  input  wire logic ul_valid,
  input  wire logic ul_bit,
  input  wire logic ul_dual_sc,
  input  wire logic ul_fast,
  output logic      ul_ready
);
  logic [7:0] rx[$];
  logic [7:0] sh;
  logic [1:0] mode;
  int         nb;
  bit         slow;
  initial {dl_sof, dl_sof_256, dl_slot, dl_pulse, dl_eof, ul_ready} = '0;
  // Reflected CRC of bytes
  function automatic logic [15:0] crc(logic [7:0] b[$]);
    crc = CRC_INIT;
    foreach (b[i]) for (int k = 0; k < 8; k++)
      crc = (crc[0] ^ b[i][k]) ? (crc >> 1) ^ CRC_POLY : crc >> 1;
  endfunction
  // One symbol: a pause in slot v of 4 or 256
  task automatic sym(logic [7:0] v, bit m);
    for (int s = 0; s < (m ? 256 : 4); s++) begin
      dl_slot <= 1'b1;
      dl_pulse <= (s == v);
      @(posedge pclk);
    end
  endtask
  // Whole frame; bad spoils one check bit
  task automatic send(logic [7:0] b[$], bit m, bit bad);
    logic [15:0] c;
    c = ~crc(b) ^ 16'(bad);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    @(posedge pclk);
    dl_sof <= 1'b1;
    dl_sof_256 <= m;
    @(posedge pclk);
    dl_sof <= 1'b0;
    foreach (b[i]) for (int k = 0; k < (m ? 1 : 4); k++) sym(m ? b[i] : 8'(b[i][2*k+:2]), m);
    dl_slot <= 1'b0;
    dl_pulse <= 1'b0;
    dl_eof <= 1'b1;
    @(posedge pclk);
    dl_eof <= 1'b0;
  endtask
  // Reply bits LSB first; slow stalls every other cycle
  always @(posedge pclk) begin
    ul_ready <= slow ? !ul_ready : 1'b1;
    if (!ul_frame) nb = 0;
    if (ul_valid && ul_ready) begin
      sh = {ul_bit, sh[7:1]};
      mode = {ul_fast, ul_dual_sc};
      nb++;
      if (nb == 8) rx.push_back(sh);
      if (nb == 8) nb = 0;
    end
  end
endmodule // vtc_reader_model

// >>> tb_vicinity_tag_command_logic.sv
// Testbench for vtc_core: request rows, then hand cases.
// Assumes the reader model and the bound checker.
module tb_vicinity_tag_command_logic import vtc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [95:0] q; int nq; logic [79:0] s; int ns;} vtc_row_t;
  localparam logic [63:0] TUID = 64'h0102030405060708; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic dl_sof, dl_sof_256, dl_slot, dl_pulse, dl_eof;
  logic ul_frame, ul_valid, ul_bit, ul_ready, ul_dual_sc, ul_fast;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, checks_done;
  vtc_row_t rows[11] = '{'{96'h80210544332211, 7, 80'h00, 1},
    '{96'h032005, 3, 80'h0044332211, 5}, '{96'h802205, 3, 80'h00, 1},
    '{96'h80210500000000, 7, 80'h0112, 2}, '{96'h00210600000000, 7, 80'h010F, 2},
    '{96'h802009, 3, 80'h0004A5A5A5A5, 6}, '{96'h260100, 3, 80'h00000807060504030201, 10},
    '{96'h80A2070102030405060708, 11, 80'h00, 1}, '{96'h80A307, 3, 80'h00, 1},
    '{96'h80210800000000, 7, 80'h0112, 2}, '{96'h22020807060504030201, 10, 80'h0, 0}};
  vtc_core #(.UID(TUID)) i_dut (.*);
  vtc_reader_model i_rdr (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("[ERR] %s exp %h got %h", nm, exp, got);
  endtask
  // One APB transfer; held until pready at an edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int t = 0; pready !== 1'b1; t++) begin
      if (t > 16) chk("pready", pready, 1);
      if (t > 16) tally_and_finish();
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Request out, reply in, bytes and check word compared
  task automatic xfer(logic [95:0] q, int nq, logic [79:0] s, int ns, bit m, bit bad);
    logic [7:0] b[$];
    for (int i = nq - 1; i >= 0; i--) b.push_back(q[8*i+:8]);
    i_rdr.rx.delete();
    i_rdr.send(b, m, bad);
    repeat (4) @(negedge pclk);
    chk("reply", 32'(ul_frame), 32'(ns != 0));
    for (int t = 0; ul_frame === 1'b1; t++) begin
      if (t > 4000) chk("end", 1, 0);
      if (t > 4000) tally_and_finish();
      @(negedge pclk);
    end
    chk("len", 32'(i_rdr.rx.size()), 32'(ns ? ns + 2 : 0));
    for (int i = 0; i < ns; i++) chk("byte", 32'(i_rdr.rx[i]), 32'(s[8*(ns-1-i)+:8]));
    if (ns != 0) chk("crc", 32'(i_rdr.crc(i_rdr.rx)), 32'(CRC_GOOD));
    if (ns != 0) chk("mode", 32'(i_rdr.mode), 32'(q[8*nq-8+:2]));
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'(er), 32'h1);
    apb(1'b0, A_IDS, 32'h0);
    chk("ids", rd, 32'h0);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_FBLK, 32'h109);
    apb(1'b1, A_FDATA, 32'hA5A5A5A5);
    foreach (rows[i]) begin
      i_rdr.slow = i[0];
      xfer(rows[i].q, rows[i].nq, rows[i].s, rows[i].ns, 1'b0, 1'b0);
    end
    xfer(96'h2020080706050403020105, 11, 80'h0044332211, 5, 1'b1, 1'b0);
    xfer(96'h2020080706050403020105, 11, 80'h0, 0, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule // tb_vicinity_tag_command_logic
